/* verilog/cec_ctrl.sv */
// Purpose: Register file, event flags and byte holding for the link engine.
// Assumes: Engine events are one-cycle pulses synchronous to core_clk.
// Notes: Received bytes queue in a FIFO until software takes the last one.
`timescale 1ns/10ps
module cec_ctrl #(
  parameter int RX_DEPTH = cec_pkg::RX_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        rx_byte_valid,
  output logic             rx_byte_ready,
  input  wire logic [7:0]  rx_byte_data,
  input  wire logic        rx_byte_header,
  input  wire logic        rx_byte_last,
  input  wire logic        rx_error_event,
  input  wire logic        tx_error_event,
  input  wire logic [6:0]  err_cause,
  input  wire logic        tx_request_event,
  input  wire logic        tx_bus_granted,
  output logic [7:0]       tx_data,
  output logic             tx_eom,
  output logic             tx_start,
  output logic             peripheral_on,
  output logic             period_error_mode,
  output logic             timing_error_mode,
  output logic             irq
);
  typedef struct packed {
    logic        on;
    logic        irq_enable;
    logic        timing_mode;
    logic        period_mode;
    logic [7:0]  csr;
    logic [6:0]  esr;
    logic [7:0]  txd;
    logic [7:0]  rxd;
    logic [31:0] rdata;
    logic        rvalid;
  } cec_ctrl_s;

  cec_ctrl_s                      state;
  cec_ctrl_s                      next_state;
  logic                           wr_cfg;
  logic                           wr_csr;
  logic                           wr_txd;
  logic                           rx_out_valid;
  logic                           rx_pop;
  logic [cec_pkg::RXW_W-1:0]      rx_in_word;
  logic [cec_pkg::RXW_W-1:0]      rx_out_word;
  logic [31:0]                    read_word;
  logic                           tx_fault_flag_clear;
  logic                           rx_fault_flag_clear;

  // Received bytes wait here; the engine is stalled when it fills.
  assign rx_in_word = {rx_byte_header, rx_byte_last, rx_byte_data};
  cec_fifo #(
    .WIDTH (cec_pkg::RXW_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rx_byte_valid),
    .in_ready  (rx_byte_ready),
    .in_data   (rx_in_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_word)
  );

  // A queued byte moves up only once software has taken the previous one.
  assign rx_pop = rx_out_valid && !state.csr[cec_pkg::CSR_RBD];

  // Write decode of the documented offsets; other offsets are ignored.
  assign wr_cfg = reg_wr && (reg_addr == cec_pkg::OFS_CONFIG);
  assign wr_csr = reg_wr && (reg_addr == cec_pkg::OFS_CTRL);
  assign wr_txd = reg_wr && (reg_addr == cec_pkg::OFS_TXBYTE);

  // A zero written to a fault flag also wipes that side's causes.
  assign tx_fault_flag_clear = wr_csr && !reg_wdata[cec_pkg::CSR_TX_FAULT_FLAG];
  assign rx_fault_flag_clear = wr_csr && !reg_wdata[cec_pkg::CSR_RX_FAULT_FLAG];

  // Read multiplexer; unmapped offsets and reserved bits read as zero.
  always_comb begin
    read_word = cec_pkg::RESET_WORD;
    case (reg_addr)
      cec_pkg::OFS_CONFIG: begin
        read_word[cec_pkg::CFG_ON]     = state.on;
        read_word[cec_pkg::CFG_IE]     = state.irq_enable;
        read_word[cec_pkg::CFG_TIMING] = state.timing_mode;
        read_word[cec_pkg::CFG_PERIOD] = state.period_mode;
      end
      cec_pkg::OFS_ERRSTAT: begin
        read_word[6:0] = state.esr;
      end
      cec_pkg::OFS_CTRL: begin
        read_word[7:0] = state.csr;
      end
      cec_pkg::OFS_TXBYTE: begin
        read_word[7:0] = state.txd;
      end
      cec_pkg::OFS_RXBYTE: begin
        read_word[7:0] = state.rxd;
      end
      default: begin
        read_word = cec_pkg::RESET_WORD;
      end
    endcase
  end

  // Next-state logic: software writes first, hardware sets win afterwards.
  always_comb begin
    next_state = state;
    next_state.rvalid = reg_rd;
    if (reg_rd) begin
      next_state.rdata = read_word;
    end
    // Configuration bits; reserved upper bits are dropped.
    if (wr_cfg) begin
      next_state.on          = reg_wdata[cec_pkg::CFG_ON];
      next_state.irq_enable  = reg_wdata[cec_pkg::CFG_IE];
      next_state.timing_mode = reg_wdata[cec_pkg::CFG_TIMING];
      next_state.period_mode = reg_wdata[cec_pkg::CFG_PERIOD];
    end
    if (wr_csr) begin
      // Event flags: a zero clears, a one keeps.
      next_state.csr = state.csr
                     & (reg_wdata[7:0] | ~cec_pkg::CSR_W0_MASK);
      // End bit changes only while neither byte-done nor receive fault flag is pending.
      if (!state.csr[cec_pkg::CSR_RBD] && !state.csr[cec_pkg::CSR_RX_FAULT_FLAG]) begin
        next_state.csr[cec_pkg::CSR_TX_MESSAGE_END] = reg_wdata[cec_pkg::CSR_TX_MESSAGE_END];
      end
    end
    // Start bit drops on grant or transmit error.
    if (tx_bus_granted || tx_error_event) begin
      next_state.csr[cec_pkg::CSR_TX_MESSAGE_BEGIN] = 1'b0;
    end
    // Software may only set the start bit; a zero has no effect.
    if (wr_csr && reg_wdata[cec_pkg::CSR_TX_MESSAGE_BEGIN]) begin
      next_state.csr[cec_pkg::CSR_TX_MESSAGE_BEGIN] = 1'b1;
    end
    // Byte to send next sits in the low eight bits.
    if (wr_txd) begin
      next_state.txd = reg_wdata[7:0];
    end
    // Error causes of each side vanish with their fault flag.
    if (tx_fault_flag_clear) begin
      next_state.esr = next_state.esr & ~cec_pkg::ESR_TX_MASK;
    end
    if (rx_fault_flag_clear) begin
      next_state.esr = next_state.esr & ~cec_pkg::ESR_RX_MASK;
    end
    // Received byte enters the read-only register.
    if (rx_pop) begin
      next_state.rxd = rx_out_word[7:0];
      next_state.csr[cec_pkg::CSR_RBD] = 1'b1;
      if (rx_out_word[cec_pkg::RXW_HDR]) begin
        next_state.csr[cec_pkg::CSR_RX_MESSAGE_BEGIN] = 1'b1;
      end
      if (rx_out_word[cec_pkg::RXW_LAST]) begin
        next_state.csr[cec_pkg::CSR_RX_MESSAGE_END] = 1'b1;
      end
    end
    // Receive fault with its cause; set beats a same-cycle clear.
    if (rx_error_event) begin
      next_state.csr[cec_pkg::CSR_RX_FAULT_FLAG] = 1'b1;
      next_state.esr = next_state.esr | (err_cause & cec_pkg::ESR_RX_MASK);
    end
    // Transmit fault with its cause.
    if (tx_error_event) begin
      next_state.csr[cec_pkg::CSR_TX_FAULT_FLAG] = 1'b1;
      next_state.esr = next_state.esr | (err_cause & cec_pkg::ESR_TX_MASK);
    end
    // Byte request, or message done when the end bit is set.
    if (tx_request_event) begin
      next_state.csr[cec_pkg::CSR_TBR] = 1'b1;
    end
  end

  // Single register bank, cleared to zero by reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs toward software and the line engine.
  assign reg_rdata         = state.rdata;
  assign reg_rvalid        = state.rvalid;
  assign tx_data           = state.txd;
  assign tx_eom            = state.csr[cec_pkg::CSR_TX_MESSAGE_END];
  assign tx_start          = state.csr[cec_pkg::CSR_TX_MESSAGE_BEGIN];
  assign peripheral_on     = state.on;
  assign period_error_mode = state.period_mode;
  assign timing_error_mode = state.timing_mode;

  // One enable gates the OR of the four interrupting flags.
  assign irq = state.irq_enable
             && (state.csr[cec_pkg::CSR_RBD] || state.csr[cec_pkg::CSR_RX_FAULT_FLAG]
              || state.csr[cec_pkg::CSR_TBR] || state.csr[cec_pkg::CSR_TX_FAULT_FLAG]);

  // Checks on the flag, data and interrupt behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_RBD_SET:
    assert property (rx_pop |=> state.csr[cec_pkg::CSR_RBD]
                     && state.rxd == $past(rx_out_word[7:0]))
    else $error("byte-done flag not set after byte moved up");
  AST_RBD_KEEP_ON_ONE:
    assert property (wr_csr && reg_wdata[cec_pkg::CSR_RBD]
                     && state.csr[cec_pkg::CSR_RBD]
                     |=> state.csr[cec_pkg::CSR_RBD])
    else $error("writing one altered byte-done flag");
  AST_FLAG_CLEAR_ZERO:
    assert property (wr_csr && !reg_wdata[cec_pkg::CSR_TBR]
                     && !tx_request_event
                     |=> !state.csr[cec_pkg::CSR_TBR] && !irq
                     || state.csr[cec_pkg::CSR_RBD]
                     || state.csr[cec_pkg::CSR_RX_FAULT_FLAG]
                     || state.csr[cec_pkg::CSR_TX_FAULT_FLAG])
    else $error("transmit request flag not cleared by zero");
  AST_RX_FAULT_FLAG_CAUSE:
    assert property (rx_error_event && err_cause[3]
                     |=> state.csr[cec_pkg::CSR_RX_FAULT_FLAG] && state.esr[3])
    else $error("receive fault or its cause missing");
  AST_EOM_FLAG:
    assert property (rx_pop && rx_out_word[cec_pkg::RXW_LAST]
                     |=> state.csr[cec_pkg::CSR_RX_MESSAGE_END])
    else $error("receive end flag not set on last byte");
  AST_SOM_FLAG:
    assert property (rx_pop && rx_out_word[cec_pkg::RXW_HDR]
                     |=> state.csr[cec_pkg::CSR_RX_MESSAGE_BEGIN])
    else $error("receive start flag not set on header");
  AST_TBR_IRQ:
    assert property (tx_request_event && state.irq_enable && !wr_cfg
                     |=> state.csr[cec_pkg::CSR_TBR] && irq)
    else $error("transmit request did not raise interrupt");
  AST_TX_FAULT_FLAG_CAUSE:
    assert property (tx_error_event && err_cause[6]
                     && !(wr_csr && reg_wdata[cec_pkg::CSR_TX_MESSAGE_BEGIN])
                     |=> state.csr[cec_pkg::CSR_TX_FAULT_FLAG] && state.esr[6]
                     && !tx_start)
    else $error("transmit fault, cause or start clear missing");
  AST_TX_MESSAGE_END_LOCK:
    assert property (wr_csr && (state.csr[cec_pkg::CSR_RBD]
                     || state.csr[cec_pkg::CSR_RX_FAULT_FLAG]) |=> $stable(tx_eom))
    else $error("end bit changed while receive flag pending");
  AST_TX_MESSAGE_END_WRITE:
    assert property (wr_csr && !state.csr[cec_pkg::CSR_RBD]
                     && !state.csr[cec_pkg::CSR_RX_FAULT_FLAG]
                     |=> tx_eom == $past(reg_wdata[cec_pkg::CSR_TX_MESSAGE_END]))
    else $error("end marker output does not follow software");
  AST_TX_MESSAGE_BEGIN_GRANT:
    assert property (tx_bus_granted && !(wr_csr
                     && reg_wdata[cec_pkg::CSR_TX_MESSAGE_BEGIN]) |=> !tx_start)
    else $error("start bit not cleared on bus grant");
  AST_TXD_LOAD:
    assert property (wr_txd |=> tx_data == $past(reg_wdata[7:0]))
    else $error("transmit byte not loaded");
  AST_RXD_RO:
    assert property (reg_wr && reg_addr == cec_pkg::OFS_RXBYTE && !rx_pop
                     |=> $stable(state.rxd))
    else $error("receive byte changed by a write");
  AST_IRQ_GATE:
    assert property (!state.irq_enable |-> !irq)
    else $error("interrupt raised while disabled");
  AST_ESR_TX_CLEAR:
    assert property (tx_fault_flag_clear && !tx_error_event
                     |=> (state.esr & cec_pkg::ESR_TX_MASK) == 7'h00)
    else $error("transmit causes survive fault clear");

  COV_MESSAGE_END: cover property (rx_pop && rx_out_word[cec_pkg::RXW_LAST]);
  COV_RX_FULL:     cover property (rx_byte_valid && !rx_byte_ready);
  COV_TX_START:    cover property (tx_start ##1 tx_bus_granted);
  COV_SET_CLEAR:   cover property (tx_request_event && wr_csr
                                   && !reg_wdata[cec_pkg::CSR_TBR]);
endmodule

/* verilog/cec_pkg.sv */
// Purpose: Shared constants for the single-wire control/status/data block.
// Assumes: One 32-bit word per register, word accesses only.
// Notes: The register offsets, field positions and masks are named here.
// How it works
// - Byte moved into receive register sets byte-done flag; interrupts when enabled.
// - Six event flags clear only on written zero; interrupt drops with them.
// - Receive error sets fault flag, cause kept in error status, interrupts.
// - Last byte of a message sets the receive end-of-message flag.
// - A received header byte sets the receive start-of-message flag.
// - Transmit request flag asks next byte, or reports message sent when ending.
// - Transmit error sets fault flag, cause kept in error status, interrupts.
// - Transmit end bit is software written; ignored while byte-done or receive fault flag set.
// - Transmit end bit selects whether the byte carries the end marker.
// - Hardware clears transmit start bit on bus grant or transmit error.
// - Transmit data register holds the next byte in its low eight bits.
// - Receive data register is read-only, holds the byte last moved up from the receive queue.
// - One interrupt enable bit gates all four interrupting events.
// - Clearing a fault flag clears that side's error status bits.
package cec_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CONFIG   = 8'h00;
  localparam logic [7:0]  OFS_ERRSTAT  = 8'h0C;
  localparam logic [7:0]  OFS_CTRL     = 8'h10;
  localparam logic [7:0]  OFS_TXBYTE   = 8'h14;
  localparam logic [7:0]  OFS_RXBYTE   = 8'h18;
  // Configuration register fields.
  localparam int          CFG_ON       = 0;
  localparam int          CFG_IE       = 1;
  localparam int          CFG_TIMING   = 2;
  localparam int          CFG_PERIOD   = 3;
  // Control and flags register fields.
  localparam int          CSR_TX_MESSAGE_BEGIN     = 0;
  localparam int          CSR_TX_MESSAGE_END     = 1;
  localparam int          CSR_TX_FAULT_FLAG     = 2;
  localparam int          CSR_TBR      = 3;
  localparam int          CSR_RX_MESSAGE_BEGIN     = 4;
  localparam int          CSR_RX_MESSAGE_END     = 5;
  localparam int          CSR_RX_FAULT_FLAG     = 6;
  localparam int          CSR_RBD      = 7;
  localparam logic [7:0]  CSR_W0_MASK  = 8'hFC;
  // Error status field groups.
  localparam int          ESR_W        = 7;
  localparam logic [6:0]  ESR_TX_MASK  = 7'h70;
  localparam logic [6:0]  ESR_RX_MASK  = 7'h1F;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  // Receive buffer word: {header, last, byte}.
  localparam int          RXW_W        = 10;
  localparam int          RXW_HDR      = 9;
  localparam int          RXW_LAST     = 8;
  localparam int          RX_DEPTH     = 16;
endpackage

/* verilog/cec_fifo.sv */
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two, at least two.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/10ps
module cec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [PW:0]                 count;
  } cec_fifo_s;
  cec_fifo_s state;
  cec_fifo_s next_state;
  logic      push;
  logic      pop;

  // Handshakes follow the occupancy directly.
  assign in_ready  = (state.count != (PW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = state.mem[state.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update; a push and pop together keep the count.
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wptr] = in_data;
      next_state.wptr = state.wptr + 1'b1;
    end
    if (pop) begin
      next_state.rptr = state.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  // Storage, pointers and count are all cleared to zero by reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

/* verif/cec_engine_model.sv */
// Purpose: Behavioural line engine facing the control/flags block.
// Assumes: Events are one-cycle pulses launched just after a clock edge.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/10ps
module cec_engine_model (
  input  wire logic core_clk,
  input  wire logic rx_byte_ready,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte_data,
  output logic       rx_byte_header,
  output logic       rx_byte_last,
  output logic       rx_error_event,
  output logic       tx_error_event,
  output logic [6:0] err_cause,
  output logic       tx_request_event,
  output logic       tx_bus_granted
);
  // All lines start idle at time zero.
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte_data = 8'h00;
    rx_byte_header = 1'b0;
    rx_byte_last = 1'b0;
    rx_error_event = 1'b0;
    tx_error_event = 1'b0;
    err_cause = 7'h00;
    tx_request_event = 1'b0;
    tx_bus_granted = 1'b0;
  end
  // Offers a byte, holds it until taken, then waits out the answer.
  task automatic send_byte(input logic [7:0] data, input logic hdr,
                           input logic last);
    int n;
    n = 0;
    @(posedge core_clk);
    #2;
    rx_byte_valid = 1'b1;
    rx_byte_data = data;
    rx_byte_header = hdr;
    rx_byte_last = last;
    while (rx_byte_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    @(posedge core_clk);
    #2;
    rx_byte_valid = 1'b0;
    rx_byte_data = ~data;
    rx_byte_header = ~hdr;
    rx_byte_last = ~last;
    @(posedge core_clk);
  endtask
  // Kind 0 rx error, 1 tx error, 2 tx request, 3 bus granted.
  task automatic pulse(input int kind, input logic [6:0] cause);
    @(posedge core_clk);
    #2;
    err_cause = cause;
    rx_error_event = (kind == 0);
    tx_error_event = (kind == 1);
    tx_request_event = (kind == 2);
    tx_bus_granted = (kind == 3);
    @(posedge core_clk);
    #2;
    rx_error_event = 1'b0;
    tx_error_event = 1'b0;
    tx_request_event = 1'b0;
    tx_bus_granted = 1'b0;
    err_cause = ~cause;
  endtask
endmodule

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the control, flags and byte registers.
// Assumes: Register reads answer one cycle after the strobe.
// Notes: Expected words are built from the field positions by hand.
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  errors++; $display("unexpected at %0t: got %h want %h", $time, got, \
  exp); end end
module tb_top;
  localparam int DEPTH = 16;
  logic        core_clk, rst, reg_wr, reg_rd, reg_rvalid, irq;
  logic [7:0]  reg_addr, tx_data, rx_byte_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic        rx_byte_valid, rx_byte_ready, rx_byte_header, rx_byte_last;
  logic        rx_error_event, tx_error_event, tx_request_event;
  logic        tx_bus_granted, tx_eom, tx_start, peripheral_on;
  logic        period_error_mode, timing_error_mode;
  logic [6:0]  err_cause;
  int          errors, num_checks;
  cec_ctrl #(.RX_DEPTH(DEPTH)) u_cec_ctrl (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
    .rx_byte_data(rx_byte_data), .rx_byte_header(rx_byte_header),
    .rx_byte_last(rx_byte_last), .rx_error_event(rx_error_event),
    .tx_error_event(tx_error_event), .err_cause(err_cause),
    .tx_request_event(tx_request_event), .tx_bus_granted(tx_bus_granted),
    .tx_data(tx_data), .tx_eom(tx_eom), .tx_start(tx_start),
    .peripheral_on(peripheral_on), .period_error_mode(period_error_mode),
    .timing_error_mode(timing_error_mode), .irq(irq));
  cec_engine_model u_cec_engine_model (.core_clk(core_clk),
    .rx_byte_ready(rx_byte_ready), .rx_byte_valid(rx_byte_valid),
    .rx_byte_data(rx_byte_data), .rx_byte_header(rx_byte_header),
    .rx_byte_last(rx_byte_last), .rx_error_event(rx_error_event),
    .tx_error_event(tx_error_event), .err_cause(err_cause),
    .tx_request_event(tx_request_event), .tx_bus_granted(tx_bus_granted));
  // Clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;
  // Writes one word with a one-cycle strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Reads one word and compares it; a missing valid reads as unknown.
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    `CHK(d, e)
  endtask
  // Reset values, config access and ignored places.
  task automatic t_reset();
    chk_reg(8'h00, 32'h0000_0000);
    chk_reg(8'h10, 32'h0000_0000);
    chk_reg(8'h14, 32'h0000_0000);
    chk_reg(8'h18, 32'h0000_0000);
    `CHK(rx_byte_ready, 1'b1)
    wr(8'h00, 32'h0000_000F);
    chk_reg(8'h00, 32'h0000_000F);
    `CHK({period_error_mode, timing_error_mode, peripheral_on}, 3'h7)
    wr(8'h18, 32'h0000_00FF);
    chk_reg(8'h18, 32'h0000_0000);
    wr(8'h04, 32'h0000_00FF);
    chk_reg(8'h04, 32'h0000_0000);
  endtask
  // Header load, start, grant, request flag in both marker modes.
  task automatic t_tx();
    wr(8'h14, 32'h0000_00A5);
    wr(8'h10, 32'h0000_00FD);
    `CHK({tx_start, tx_data}, 9'h1A5)
    chk_reg(8'h14, 32'h0000_00A5);
    u_cec_engine_model.pulse(3, 7'h00);
    `CHK(tx_start, 1'b0)
    u_cec_engine_model.pulse(2, 7'h00);
    chk_reg(8'h10, 32'h0000_0008);
    `CHK(irq, 1'b1)
    wr(8'h10, 32'h0000_00FC);
    chk_reg(8'h10, 32'h0000_0008);
    wr(8'h10, 32'h0000_00F4);
    `CHK(irq, 1'b0)
    wr(8'h10, 32'h0000_00FE);
    `CHK(tx_eom, 1'b1)
    u_cec_engine_model.pulse(2, 7'h00);
    chk_reg(8'h10, 32'h0000_000A);
    wr(8'h10, 32'h0000_00F4);
    `CHK(tx_eom, 1'b0)
    chk_reg(8'h10, 32'h0000_0000);
  endtask
  // Both fault flags, their causes, gating and side-wise clearing.
  task automatic t_err();
    wr(8'h10, 32'h0000_00FD);
    u_cec_engine_model.pulse(1, 7'h7F);
    `CHK({tx_start, irq}, 2'b01)
    chk_reg(8'h0C, 32'h0000_0070);
    u_cec_engine_model.pulse(0, 7'h7F);
    chk_reg(8'h0C, 32'h0000_007F);
    chk_reg(8'h10, 32'h0000_0044);
    wr(8'h00, 32'h0000_000D);
    `CHK(irq, 1'b0)
    wr(8'h00, 32'h0000_000F);
    wr(8'h10, 32'h0000_00F8);
    chk_reg(8'h0C, 32'h0000_000F);
    `CHK(irq, 1'b1)
    wr(8'h10, 32'h0000_00BC);
    chk_reg(8'h0C, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask
  // A two-byte message with the end marker write locked out meanwhile.
  task automatic t_rx();
    u_cec_engine_model.send_byte(8'h40, 1'b1, 1'b0);
    chk_reg(8'h18, 32'h0000_0040);
    chk_reg(8'h10, 32'h0000_0090);
    `CHK(irq, 1'b1)
    wr(8'h10, 32'h0000_00FE);
    `CHK(tx_eom, 1'b0)
    u_cec_engine_model.send_byte(8'h3C, 1'b0, 1'b1);
    chk_reg(8'h18, 32'h0000_0040);
    wr(8'h10, 32'h0000_007C);
    chk_reg(8'h18, 32'h0000_003C);
    chk_reg(8'h10, 32'h0000_00B0);
    wr(8'h10, 32'h0000_0000);
    chk_reg(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h0000_00FE);
    `CHK(tx_eom, 1'b1)
    wr(8'h10, 32'h0000_00F4);
  endtask
  // Fills the receive queue until it refuses, then drains it in order.
  task automatic t_fifo();
    for (int i = 0; i <= DEPTH; i++) begin
      u_cec_engine_model.send_byte(8'(i + 1), 1'b0, 1'b0);
    end
    #2;
    `CHK(rx_byte_ready, 1'b0)
    for (int i = 0; i <= DEPTH; i++) begin
      chk_reg(8'h18, 32'(i + 1));
      wr(8'h10, 32'h0000_007C);
    end
    `CHK(rx_byte_ready, 1'b1)
    chk_reg(8'h10, 32'h0000_0000);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #(25 * 20000);
    errors++;
    print_verdict();
  end
  // Reset for four cycles, then the scenarios in turn.
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    errors = 0;
    num_checks = 0;
    repeat (4) @(posedge core_clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_tx();
    t_err();
    t_rx();
    t_fifo();
    print_verdict();
  end
endmodule
